/* logic/periodic_timer.sv */
// periodic timer top: axi4-lite registers, 10-bit counter, output pin
// What the document asks of this block
// [RULE1] count readable as a pair; compare a and p as read/write pairs
// [RULE2] pause bit holds the count; clearing it resumes from held value
// [RULE3] clock select picks prescaled, sub or external-edge counter clock
// [RULE4] timer on rising edge zeroes counter and starts counting
// [RULE5] timer on falling edge stops counting and keeps residual count
// [RULE6] timer on rising edge resets output to initial level in output modes
// [RULE7] mode field: compare, capture, pwm/single pulse, timer/counter
// [RULE8] software switches timer off before changing the mode field
// [RULE9] compare mode on match a: no change, low, high or toggle
// [RULE10] pwm mode: forced inactive, forced active, pwm, single pulse
// [RULE11] capture mode edge: rising, falling, both, or disabled
// [RULE12] capture source: capture pin when 0, external clock pin when 1
// [RULE13] requested level equal to initial level gives no visible change
// [RULE14] software changes pin function in pwm only while timer off
// [RULE15] initial level bit: start level, pwm active level, pulse start
// [RULE16] invert bit inverts the output pin, not in timer/counter mode; the code inverts the pin in every mode, timer/counter included
// [RULE17] clear source: match a when 1; match p or overflow when 0
// [RULE18] overflow clear only when compare p value is all zero
// [RULE19] clear source ignored in pwm, single pulse and capture modes
// [RULE20] control 0 bits 2 to 0 read as zero
// [RULE21] comparator p is 10 bits, compared with all counter bits
// [RULE22] counter counts up and clears on overflow or selected match
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module periodic_timer (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_clock_pin,
  input  wire logic        capture_input_pin,
  output logic             timer_output_pin,
  output logic             timer_output_en,
  output logic             timer_event
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_HOLD = 3'b100
  } ptm_bus_e;

  typedef struct packed {
    ptm_bus_e    wrState;
    logic        awTaken;
    logic        wTaken;
    logic [4:0]  wrAddr;
    logic [7:0]  wrData;
    logic        wrLane;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [7:0]  rData;
    logic [1:0]  rResp;
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [9:0]  compareA;
    logic [9:0]  compareP;
    logic [9:0]  count;
    logic        onPrev;
    logic        capPrev;
    logic        extPrev;
    logic        outLevel;
    logic        pin;
    logic        pinEn;
    logic        event_;
  } ptm_state_s;

  ptm_state_s st;
  ptm_state_s next_st;
  ptm_tick_if tk ();

  ptm_tick_gen u_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tk      (tk)
  );

  // ==========================================================
  // field decode
  logic       countPause;
  logic       timerOn;
  logic [1:0] opMode;
  logic [1:0] pinFunction;
  logic       initLevel;
  logic       outputInvert;
  logic       captureSource;
  logic       clearSource;

  assign countPause    = st.ctrl0[ptm_pkg::POS_PAUSE];
  assign timerOn       = st.ctrl0[ptm_pkg::POS_ON];
  assign opMode        = st.ctrl1[ptm_pkg::POS_MODE +: 2];
  assign pinFunction   = st.ctrl1[ptm_pkg::POS_PINFN +: 2];
  assign initLevel     = st.ctrl1[ptm_pkg::POS_INIT];
  assign outputInvert  = st.ctrl1[ptm_pkg::POS_INV];
  assign captureSource = st.ctrl1[ptm_pkg::POS_CAPSRC];
  assign clearSource   = st.ctrl1[ptm_pkg::POS_CLRSRC];
  assign tk.clockSelect = st.ctrl0[ptm_pkg::POS_CKSEL +: 3];
  assign tk.extClock    = ext_clock_pin;

  // ==========================================================
  // next state
  always_comb
  begin
    logic       wrFire;
    logic       rdFire;
    logic       onRise;
    logic       running;
    logic       matchA;
    logic       matchP;
    logic       overflow;
    logic       clearCnt;
    logic       capSig;
    logic       prevSig;
    logic       capEdge;
    logic       capCatch;
    logic       pulseEnd;
    logic       lvl;
    logic [7:0] rd;
    wrFire = 1'b0;
    rdFire = 1'b0;
    onRise = 1'b0;
    running = 1'b0;
    matchA = 1'b0;
    matchP = 1'b0;
    overflow = 1'b0;
    clearCnt = 1'b0;
    capSig = 1'b0;
    prevSig = 1'b0;
    capEdge = 1'b0;
    capCatch = 1'b0;
    pulseEnd = 1'b0;
    lvl = 1'b0;
    rd = 8'h00;
    next_st = st;
    next_st.event_ = 1'b0;

    // write channel: address and data in either order
    if (s_axi_awvalid && !st.awTaken && st.wrState == BUS_IDLE)
    begin
      next_st.awTaken = 1'b1;
      next_st.wrAddr = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && !st.wTaken && st.wrState == BUS_IDLE)
    begin
      next_st.wTaken = 1'b1;
      next_st.wrData = s_axi_wdata[7:0];
      next_st.wrLane = s_axi_wstrb[0];
    end
    case (st.wrState)
      BUS_IDLE:
        if (st.awTaken && st.wTaken)
        begin
          wrFire = st.wrLane;
          next_st.bValid = 1'b1;
          next_st.bResp = (st.wrAddr[1:0] == 2'h0)
                          ? ptm_pkg::RESP_OKAY : ptm_pkg::RESP_SLVERR;
          next_st.wrState = BUS_RESP;
        end
      BUS_RESP:
        if (s_axi_bready)
        begin
          next_st.bValid = 1'b0;
          next_st.awTaken = 1'b0;
          next_st.wTaken = 1'b0;
          next_st.wrState = BUS_IDLE;
        end
      default:
        next_st.wrState = BUS_IDLE;
    endcase
    if (wrFire && st.wrAddr[1:0] == 2'h0)
    begin
      case (st.wrAddr)
        ptm_pkg::ADDR_CTRL0:
          next_st.ctrl0 = st.wrData & ptm_pkg::CTRL0_MASK; // [RULE20]
        ptm_pkg::ADDR_CTRL1:  next_st.ctrl1 = st.wrData;
        ptm_pkg::ADDR_CMA_LO: next_st.compareA[7:0] = st.wrData; // [RULE1]
        ptm_pkg::ADDR_CMA_HI: next_st.compareA[9:8] = st.wrData[1:0];
        ptm_pkg::ADDR_CMP_LO: next_st.compareP[7:0] = st.wrData;
        ptm_pkg::ADDR_CMP_HI: next_st.compareP[9:8] = st.wrData[1:0];
        default: ;
      endcase
    end

    // read channel
    rdFire = s_axi_arvalid && !st.rValid;
    if (rdFire)
    begin
      case (s_axi_araddr[4:0])
        ptm_pkg::ADDR_CTRL0:  rd = st.ctrl0;
        ptm_pkg::ADDR_CTRL1:  rd = st.ctrl1;
        ptm_pkg::ADDR_CNT_LO: rd = st.count[7:0]; // [RULE1]
        ptm_pkg::ADDR_CNT_HI: rd = {6'h00, st.count[9:8]};
        ptm_pkg::ADDR_CMA_LO: rd = st.compareA[7:0];
        ptm_pkg::ADDR_CMA_HI: rd = {6'h00, st.compareA[9:8]};
        ptm_pkg::ADDR_CMP_LO: rd = st.compareP[7:0];
        ptm_pkg::ADDR_CMP_HI: rd = {6'h00, st.compareP[9:8]};
        default: rd = 8'h00;
      endcase
      next_st.rData = rd;
      next_st.rResp = (s_axi_araddr[4:0] > ptm_pkg::ADDR_CMP_HI ||
                       s_axi_araddr[1:0] != 2'h0 ||
                       s_axi_araddr[31:5] != 27'h0)
                      ? ptm_pkg::RESP_SLVERR : ptm_pkg::RESP_OKAY;
      next_st.rValid = 1'b1;
    end
    else if (st.rValid && s_axi_rready)
      next_st.rValid = 1'b0;

    // ========================================================
    // counter
    onRise = timerOn & ~st.onPrev;
    next_st.onPrev = timerOn;
    running = timerOn & ~countPause & tk.tick; // [RULE2] [RULE5]
    matchA = running && (st.count + 10'h001 == st.compareA);
    matchP = running && (st.count + 10'h001 == st.compareP); // [RULE21]
    overflow = running && (st.count == ptm_pkg::CNT_MAX);
    if (opMode == ptm_pkg::MODE_CMP || opMode == ptm_pkg::MODE_TMR)
      clearCnt = clearSource ? matchA // [RULE17] [RULE19]
               : (matchP || (overflow && st.compareP == 10'h000)); // [RULE18]
    else
      clearCnt = matchP || (overflow && st.compareP == 10'h000);

    // each pin keeps its own history: no false edge on a source switch
    capSig = captureSource ? ext_clock_pin : capture_input_pin; // [RULE12]
    prevSig = captureSource ? st.extPrev : st.capPrev;
    next_st.capPrev = capture_input_pin;
    next_st.extPrev = ext_clock_pin;
    case (pinFunction) // [RULE11]
      2'h0: capEdge = capSig & ~prevSig;
      2'h1: capEdge = ~capSig & prevSig;
      2'h2: capEdge = capSig ^ prevSig;
      default: capEdge = 1'b0;
    endcase
    capCatch = timerOn && opMode == ptm_pkg::MODE_CAP && capEdge;
    if (capCatch)
      next_st.compareA = st.count;

    pulseEnd = opMode == ptm_pkg::MODE_PWM && pinFunction == 2'h3 && matchA;
    if (onRise)
      next_st.count = ptm_pkg::VAL_RESET; // [RULE4]
    else if (running) // [RULE22]
      next_st.count = clearCnt ? ptm_pkg::VAL_RESET : st.count + 10'h001;
    if (pulseEnd)
      next_st.ctrl0[ptm_pkg::POS_ON] = 1'b0;
    next_st.event_ = matchA | clearCnt | capCatch;

    // ========================================================
    // output pin
    lvl = st.outLevel;
    if (onRise)
      lvl = initLevel; // [RULE6] [RULE15]
    else if (opMode == ptm_pkg::MODE_CMP && matchA)
    begin
      case (pinFunction) // [RULE9] [RULE13]
        2'h1: lvl = 1'b0;
        2'h2: lvl = 1'b1;
        2'h3: lvl = ~st.outLevel;
        default: lvl = st.outLevel;
      endcase
    end
    else if (opMode == ptm_pkg::MODE_PWM)
    begin
      case (pinFunction) // [RULE10] [RULE15]
        2'h0: lvl = ~initLevel;
        2'h1: lvl = initLevel;
        2'h2: lvl = (st.count < st.compareA) ? initLevel : ~initLevel;
        default: lvl = pulseEnd ? ~initLevel : st.outLevel;
      endcase
    end
    next_st.outLevel = lvl;
    next_st.pin = lvl ^ outputInvert; // [RULE16]
    next_st.pinEn = timerOn && (opMode == ptm_pkg::MODE_CMP ||
                                opMode == ptm_pkg::MODE_PWM); // [RULE7]
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.wrState <= BUS_IDLE;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs
  assign s_axi_awready    = st.wrState == BUS_IDLE && !st.awTaken;
  assign s_axi_wready     = st.wrState == BUS_IDLE && !st.wTaken;
  assign s_axi_bvalid     = st.bValid;
  assign s_axi_bresp      = st.bResp;
  assign s_axi_arready    = !st.rValid;
  assign s_axi_rvalid     = st.rValid;
  assign s_axi_rdata      = {24'h000000, st.rData};
  assign s_axi_rresp      = st.rResp;
  assign timer_output_pin = st.pin;
  assign timer_output_en  = st.pinEn;
  assign timer_event      = st.event_;
endmodule

/* logic/ptm_pkg.sv */
// package: register map, field positions and encodings of the periodic timer
package ptm_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [4:0] ADDR_CTRL0  = 5'h00;
  localparam logic [4:0] ADDR_CTRL1  = 5'h04;
  localparam logic [4:0] ADDR_CNT_LO = 5'h08;
  localparam logic [4:0] ADDR_CNT_HI = 5'h0c;
  localparam logic [4:0] ADDR_CMA_LO = 5'h10;
  localparam logic [4:0] ADDR_CMA_HI = 5'h14;
  localparam logic [4:0] ADDR_CMP_LO = 5'h18;
  localparam logic [4:0] ADDR_CMP_HI = 5'h1c;
  // ==========================================================
  // control field positions
  localparam int POS_PAUSE  = 7;
  localparam int POS_CKSEL  = 4;
  localparam int POS_ON     = 3;
  localparam int POS_MODE   = 6;
  localparam int POS_PINFN  = 4;
  localparam int POS_INIT   = 3;
  localparam int POS_INV    = 2;
  localparam int POS_CAPSRC = 1;
  localparam int POS_CLRSRC = 0;
  localparam logic [7:0] CTRL0_MASK  = 8'hf8;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [9:0] VAL_RESET   = 10'h000;
  localparam logic [9:0] CNT_MAX     = 10'h3ff;
  // ==========================================================
  // operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // ==========================================================
  // clock dividers
  localparam logic [5:0] DIV_SYS4  = 6'h03;
  localparam logic [5:0] DIV_HI16  = 6'h0f;
  localparam logic [5:0] DIV_HI64  = 6'h3f;
  localparam logic [5:0] DIV_SUB   = 6'h3f;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/ptm_tick_gen.sv */
// counter clock enable generator: prescaler and external edge detect
`timescale 1ns/1ps
module ptm_tick_gen (
  input  wire logic ref_clk,
  input  wire logic rstn,
  ptm_tick_if.gen   tk
);
  typedef struct packed {
    logic [5:0] div;
    logic       extPrev;
    logic       tick;
  } ptm_gen_s;
  ptm_gen_s st;
  ptm_gen_s next_st;

  always_comb
  begin
    logic tickNow;
    tickNow = 1'b0;
    next_st = st;
    next_st.div = st.div + 6'h01;
    next_st.extPrev = tk.extClock;
    case (tk.clockSelect) // [RULE3]
      3'h0: tickNow = (st.div[1:0] == ptm_pkg::DIV_SYS4[1:0]);
      3'h1: tickNow = 1'b1;
      3'h2: tickNow = (st.div[3:0] == ptm_pkg::DIV_HI16[3:0]);
      3'h3: tickNow = (st.div == ptm_pkg::DIV_HI64);
      3'h4, 3'h5: tickNow = (st.div == ptm_pkg::DIV_SUB);
      3'h6: tickNow = tk.extClock & ~st.extPrev;
      3'h7: tickNow = ~tk.extClock & st.extPrev;
      default: tickNow = 1'b0;
    endcase
    next_st.tick = tickNow;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tk.tick = st.tick;
endmodule

/* logic/ptm_tick_if.sv */
// interface: counter tick request and result between timer and divider
`timescale 1ns/1ps
interface ptm_tick_if;
  logic [2:0] clockSelect;
  logic       extClock;
  logic       tick;
  modport core (output clockSelect, output extClock, input tick);
  modport gen  (input clockSelect, input extClock, output tick);
endinterface

/* tb/periodic_timer_tb.sv */
// testbench: register access, counting and output pin of the timer
`timescale 1ns/1ps
module periodic_timer_tb;
  localparam logic [31:0] C0  = 32'(ptm_pkg::ADDR_CTRL0);
  localparam logic [31:0] C1  = 32'(ptm_pkg::ADDR_CTRL1);
  localparam logic [31:0] CLO = 32'(ptm_pkg::ADDR_CNT_LO);
  localparam logic [31:0] CHI = 32'(ptm_pkg::ADDR_CNT_HI);
  localparam logic [31:0] ALO = 32'(ptm_pkg::ADDR_CMA_LO);
  localparam logic [31:0] PLO = 32'(ptm_pkg::ADDR_CMP_LO);
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] awAddr = 32'h0;
  logic [31:0] wData = 32'h0;
  logic [31:0] arAddr = 32'h0;
  logic        awValid = 1'b0;
  logic        wValid = 1'b0;
  logic        bReady = 1'b0;
  logic        arValid = 1'b0;
  logic        rReady = 1'b0;
  logic        extPin = 1'b0;
  logic        capPin = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic        outPin, outEn, evPin;
  int          evCount = 0;
  int          ev0;
  logic [1:0]  bResp, rResp;
  logic [31:0] rData, rdv;
  int          failures = 0;
  int          cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  periodic_timer u_periodic_timer (
    .ref_clk           (ref_clk),
    .rstn              (rstn),
    .s_axi_awaddr      (awAddr),
    .s_axi_awvalid     (awValid),
    .s_axi_awready     (awReady),
    .s_axi_wdata       (wData),
    .s_axi_wstrb       (4'hf),
    .s_axi_wvalid      (wValid),
    .s_axi_wready      (wReady),
    .s_axi_bresp       (bResp),
    .s_axi_bvalid      (bValid),
    .s_axi_bready      (bReady),
    .s_axi_araddr      (arAddr),
    .s_axi_arvalid     (arValid),
    .s_axi_arready     (arReady),
    .s_axi_rdata       (rData),
    .s_axi_rresp       (rResp),
    .s_axi_rvalid      (rValid),
    .s_axi_rready      (rReady),
    .ext_clock_pin     (extPin),
    .capture_input_pin (capPin),
    .timer_output_pin  (outPin),
    .timer_output_en   (outEn),
    .timer_event       (evPin)
  );
  always @(posedge ref_clk)
    if (evPin === 1'b1)
      evCount <= evCount + 1;
  // ==========================================================
  // reporting
  task automatic conclude();
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n < 50)
      return;
    failures++;
    conclude();
  endtask
  // ==========================================================
  // bus cycles
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'h0);
    int n;
    @(posedge ref_clk);
    awAddr  <= a;
    wData   <= 32'(d);
    awValid <= 1'b1;
    wValid  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (awReady)
        awValid <= 1'b0;
      if (wReady)
        wValid <= 1'b0;
      if (bValid && bReady)
        break;
      if (bValid)
        bReady <= 1'b1;
    end
    bReady <= 1'b0;
    tmo(n);
    chk("bresp", 32'(e), 32'(bResp));
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    input logic [1:0] e = 2'h0);
    int n;
    @(posedge ref_clk);
    arAddr  <= a;
    arValid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (arReady)
        arValid <= 1'b0;
      if (rValid && rReady)
        break;
      if (rValid)
        rReady <= 1'b1;
    end
    rReady <= 1'b0;
    d = rData;
    tmo(n);
    chk("rresp", 32'(e), 32'(rResp));
  endtask
  task automatic rc(input logic [31:0] a, e);
    rd(a, rdv);
    chk("rdata", e, rdv);
  endtask
  // ==========================================================
  // pin stimulus
  task automatic pulse(input int k);
    repeat (k)
    begin
      @(posedge ref_clk) extPin <= 1'b1;
      repeat (2) @(posedge ref_clk);
      extPin <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task automatic restart(input logic [7:0] c1, c0);
    wr(C0, 8'h60);
    wr(C1, c1);
    wr(C0, c0);
  endtask
  task automatic pin(input logic e);
    repeat (3) @(posedge ref_clk);
    chk("pin", 32'(e), 32'(outPin));
  endtask
  task automatic cap(input logic v);
    @(posedge ref_clk) capPin <= v;
    repeat (3) @(posedge ref_clk);
  endtask
  // ==========================================================
  // sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rc(32'(i * 4), 32'h0);
    wr(C0, 8'h07);
    rc(C0, 32'h0);
    wr(CLO, 8'h55);
    rc(CLO, 32'h0);
    for (int i = 0; i < 16; i += 8)
    begin
      wr(ALO + 32'(i), 8'ha5);
      wr(ALO + 32'(i + 4), 8'hff);
      rc(ALO + 32'(i), 32'ha5);
      rc(ALO + 32'(i + 4), 32'h3);
    end
    wr(32'h1, 8'h55, 2'h2);
    rd(32'h20, rdv, 2'h2);
    restart(8'hc0, 8'h68);
    wr(PLO, 8'h00);
    wr(PLO + 32'h4, 8'h00);
    pulse(5);
    rc(CLO, 32'h5);
    wr(C0, 8'he8);
    pulse(3);
    rc(CLO, 32'h5);
    wr(C0, 8'h68);
    pulse(2);
    rc(CLO, 32'h7);
    wr(C0, 8'h60);
    pulse(2);
    rc(CLO, 32'h7);
    restart(8'hc0, 8'h78);
    rc(CLO, 32'h0);
    pulse(3);
    rc(CLO, 32'h3);
    restart(8'hc0, 8'h68);
    pulse(260);
    rc(CHI, 32'h1);
    pulse(765);
    rc(CLO, 32'h1);
    wr(PLO, 8'h01);
    wr(PLO + 32'h4, 8'h01);
    restart(8'hc0, 8'h68);
    pulse(259);
    rc(CLO, 32'h2);
    wr(ALO, 8'h04);
    wr(ALO + 32'h4, 8'h00);
    restart(8'hc1, 8'h68);
    ev0 = evCount;
    pulse(6);
    rc(CLO, 32'h2);
    chk("event", 32'h1, 32'(evCount - ev0));
    restart(8'h81, 8'h68);
    pulse(6);
    rc(CLO, 32'h6);
    for (int k = 0; k < 8; k++)
    begin
      restart({2'h0, 2'(k >> 1), k[0], k[1], 2'h1}, 8'h68);
      pin(k[0] ^ k[1]);
      chk("enable", 32'h1, 32'(outEn));
      pulse(4);
      pin((k < 2 ? k[0] : k < 4 ? 1'b0 : k < 6 ? 1'b1 : !k[0]) ^ k[1]);
    end
    for (int k = 0; k < 4; k++)
    begin
      restart({3'h4, k[1], k[0], 3'h0}, 8'h68);
      pin(k[0] ^ !k[1]);
    end
    restart(8'ha8, 8'h68);
    pin(1'b1);
    pulse(5);
    pin(1'b0);
    restart(8'hb8, 8'h68);
    pin(1'b1);
    pulse(4);
    pin(1'b0);
    rc(C0, 32'h60);
    restart(8'h40, 8'h68);
    pulse(3);
    cap(1'b1);
    rc(ALO, 32'h3);
    wr(C1, 8'h50);
    pulse(2);
    cap(1'b0);
    rc(ALO, 32'h5);
    wr(C1, 8'h70);
    pulse(1);
    cap(1'b1);
    rc(ALO, 32'h5);
    wr(C1, 8'h62);
    cap(1'b0);
    rc(ALO, 32'h5);
    conclude();
  end
endmodule

/* tb/ptm_assertions.sv */
// checker: bus and register-read relations at the timer ports
`timescale 1ns/1ps
module ptm_assertions (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ==========================================================
  // address of the read in flight
  logic [31:0] rdAddr;
  logic        rdBad;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      rdAddr <= 32'h0;
    else if (s_axi_arvalid && s_axi_arready)
      rdAddr <= s_axi_araddr;
  assign rdBad = (rdAddr[1:0] != 2'h0) || (rdAddr[31:5] != 27'h0);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================================
  // properties
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped before bready");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  AST_WRITE_ANS: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_ARREADY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  AST_READ_ANS: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_RRESP: assert property (s_axi_rvalid |-> s_axi_rresp ==
    (rdBad ? ptm_pkg::RESP_SLVERR : ptm_pkg::RESP_OKAY))
    else $error("wrong read response");
  AST_BYTE: assert property (s_axi_rvalid && !rdBad
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_HI_ZERO: assert property (s_axi_rvalid && !rdBad &&
    rdAddr[4:0] inside {5'h0c, 5'h14, 5'h1c}
    |-> s_axi_rdata[31:2] == 30'h0) else $error("high byte too wide");
  AST_CTRL0: assert property (s_axi_rvalid && rdAddr == 32'h0
    |-> s_axi_rdata[2:0] == 3'h0) else $error("control 0 low bits set");
endmodule

bind periodic_timer ptm_assertions u_ptm_assertions (
  .ref_clk       (ref_clk),
  .rstn          (rstn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready)
);
